//--- hdl/e3n_rx_device.sv
// device end: g.832 alignment and nibble-parallel receive output
`include "e3n_params.svh"
`default_nettype none

module e3n_rx_device (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_line_clk,
  input wire logic i_line_data,
  input wire logic i_nibble_mode_select,
  input wire logic [15:0] i_reg_addr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  output logic o_frame_locked,
  output logic [1:0] o_format,
  e3n_if.dev bus
);
  import e3n_pkg::*;

  // ==========================================================
  // state of each clock domain
  typedef struct packed {
    logic [7:0] global_operation_select;
    logic [7:0] framing_mode_control;
    logic [7:0] payload_packet_control;
    logic [7:0] rdata;
    logic path_go;
    logic [1:0] format;
    logic lock_meta;
    logic lock_sync;
  } e3n_ref_state_t;

  typedef struct packed {
    logic go_meta;
    logic go_sync;
    logic mode_meta;
    logic mode_sync;
    logic [19:0] shift;
    logic [12:0] bit_pos;
    e3n_sync_t sync;
    logic nclk;
    logic [3:0] nib;
    logic frame;
    logic oh;
  } e3n_line_state_t;

  e3n_ref_state_t r_q;
  e3n_ref_state_t next_r;
  e3n_line_state_t l_q;
  e3n_line_state_t next_l;

  // ==========================================================
  // overhead byte map: fa1, fa2, then column 0 of rows 1 to 5
  function automatic logic is_oh_byte(input logic [9:0] idx);
    logic hit;
    hit = 1'b0;
    unique case (idx)
      10'h000, 10'h001, 10'h03C, 10'h078, 10'h0B4, 10'h0F0, 10'h12C: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // register write with its writable mask
  function automatic logic [7:0] reg_write(input logic [7:0] old, input logic [7:0] wdata,
                                           input logic [7:0] mask);
    return (old & ~mask) | (wdata & mask);
  endfunction

  // ==========================================================
  // register port, reference clock domain
  logic [12:0] start_bit;
  logic fa_hit;

  always_comb begin
    next_r = r_q;
    next_r.lock_meta = l_q.sync == E3N_LOCKED;
    next_r.lock_sync = r_q.lock_meta;
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        `E3N_OFS_GLOBAL_OP_SEL: begin
          next_r.global_operation_select = reg_write(r_q.global_operation_select, i_reg_wdata,
                                                     `E3N_MSK_GLOBAL_OP_SEL);
        end
        `E3N_OFS_FRAMING_MODE: begin
          next_r.framing_mode_control = reg_write(r_q.framing_mode_control, i_reg_wdata,
                                                  `E3N_MSK_FRAMING_MODE);
        end
        `E3N_OFS_PAYLOAD_PKT: begin
          next_r.payload_packet_control = reg_write(r_q.payload_packet_control, i_reg_wdata,
                                                    `E3N_MSK_PAYLOAD_PKT);
        end
        default: begin
        end
      endcase
    end
    if (i_reg_rd) begin
      unique case (i_reg_addr)
        `E3N_OFS_GLOBAL_OP_SEL: next_r.rdata = r_q.global_operation_select;
        `E3N_OFS_FRAMING_MODE: next_r.rdata = r_q.framing_mode_control;
        `E3N_OFS_PAYLOAD_PKT: next_r.rdata = r_q.payload_packet_control;
        default: next_r.rdata = 8'h00;
      endcase
    end
    // one format drives both framer directions, so it is exported as a level
    next_r.format = {r_q.framing_mode_control[`E3N_BIT_DS3_SELECT],
                     r_q.framing_mode_control[`E3N_BIT_FORMAT]};
    next_r.path_go = r_q.global_operation_select[`E3N_BIT_CFG_CONTROL]
                     & ~r_q.payload_packet_control[`E3N_BIT_PKT_ENABLE]
                     & (e3n_format_t'(r_q.format) == E3N_FMT_G832);
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r_q <= '0;
      r_q.global_operation_select <= `E3N_RST_GLOBAL_OP_SEL;
      r_q.framing_mode_control <= `E3N_RST_FRAMING_MODE;
      r_q.payload_packet_control <= `E3N_RST_PAYLOAD_PKT;
      r_q.format <= E3N_FMT_G751;
    end else begin
      r_q <= next_r;
    end
  end

  assign o_reg_rdata = r_q.rdata;
  assign o_frame_locked = r_q.lock_sync;
  assign o_format = r_q.format;

  // ==========================================================
  // line domain: alignment search and nibble output
  always_comb begin
    next_l = l_q;
    // configuration and the select pin are quasi-static levels
    next_l.go_meta = r_q.path_go;
    next_l.go_sync = l_q.go_meta;
    next_l.mode_meta = i_nibble_mode_select;
    next_l.mode_sync = l_q.mode_meta;
    next_l.shift = {l_q.shift[18:0], i_line_data};
    if (l_q.bit_pos == `E3N_FRAME_BITS - 13'h0001) begin
      next_l.bit_pos = 13'h0000;
    end else begin
      next_l.bit_pos = l_q.bit_pos + 13'h0001;
    end
    fa_hit = next_l.shift[15:0] == {`E3N_ALIGN_ONE, `E3N_ALIGN_TWO};
    unique case (l_q.sync)
      E3N_HUNT: begin
        if (fa_hit && l_q.go_sync) begin
          next_l.sync = E3N_LOCKED;
          next_l.bit_pos = `E3N_LOCK_NEXT_BIT;
        end
      end
      E3N_LOCKED: begin
        if (!l_q.go_sync) begin
          next_l.sync = E3N_HUNT;
        end else if (l_q.bit_pos == `E3N_FA_END_BIT && !fa_hit) begin
          next_l.sync = E3N_HUNT;
        end
      end
    endcase
    // output lags the line by the alignment window so the marker can land on fa1
    if (l_q.bit_pos >= `E3N_OUT_DELAY) begin
      start_bit = l_q.bit_pos - `E3N_OUT_DELAY;
    end else begin
      start_bit = l_q.bit_pos + (`E3N_FRAME_BITS - `E3N_OUT_DELAY);
    end
    if (l_q.bit_pos[1:0] == 2'b11) begin
      if (l_q.sync == E3N_LOCKED && l_q.mode_sync) begin
        next_l.nib = next_l.shift[19:16];
        next_l.frame = start_bit == 13'h0000;
        next_l.oh = is_oh_byte(start_bit[12:3]);
      end else begin
        next_l.nib = 4'h0;
        next_l.frame = 1'b0;
        next_l.oh = 1'b0;
      end
    end
    // divide by four; data changes on the edge where this clock falls
    next_l.nclk = l_q.mode_sync & next_l.bit_pos[1];
  end

  always_ff @(posedge i_line_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      l_q <= '0;
      l_q.sync <= E3N_HUNT;
    end else begin
      l_q <= next_l;
    end
  end

  assign bus.rx_nibble_clock = l_q.nclk;
  assign bus.rx_nibble_bus = l_q.nib;
  assign bus.rx_frame_marker = l_q.frame;
  assign bus.rx_overhead_flag = l_q.oh;

endmodule
`default_nettype wire

//--- hdl/e3n_sys_sink.sv
// terminal end: captures nibbles and hands payload bytes to the system
`include "e3n_params.svh"
`default_nettype none
module e3n_sys_sink (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  e3n_if.sys bus,
  output logic [7:0] o_byte,
  output logic o_byte_valid,
  output logic o_frame_start,
  output logic o_align_ok
);
  import e3n_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [3:0] hi;
    logic half;
    logic [7:0] byte_hold;
    logic byte_tog;
    logic frame_tog;
    logic [1:0] fa_cnt;
    logic fa_ok;
    logic align_ok;
  } e3n_cap_state_t;

  typedef struct packed {
    logic [2:0] btog;
    logic [2:0] ftog;
    logic [1:0] ok;
    logic [7:0] data;
    logic valid;
    logic frame;
  } e3n_sys_state_t;

  e3n_cap_state_t c_q;
  e3n_cap_state_t next_c;
  e3n_sys_state_t s_q;
  e3n_sys_state_t next_s;
  logic [15:0] fa_word;

  // ==========================================================
  // capture on the rising nibble clock edge
  always_comb begin
    next_c = c_q;
    fa_word = {`E3N_ALIGN_ONE, `E3N_ALIGN_TWO};
    if (bus.rx_frame_marker) begin
      next_c.frame_tog = ~c_q.frame_tog;
      next_c.half = 1'b0;
      next_c.fa_cnt = 2'b01;
      next_c.fa_ok = bus.rx_nibble_bus == fa_word[15:12];
    end else if (c_q.fa_cnt != 2'b00) begin
      next_c.fa_cnt = c_q.fa_cnt + 2'b01;
      next_c.fa_ok = c_q.fa_ok & (bus.rx_nibble_bus == fa_word[4'(15 - 4 * c_q.fa_cnt) -: 4]);
      if (c_q.fa_cnt == 2'b11) begin
        next_c.align_ok = next_c.fa_ok;
      end
    end
    // overhead nibbles are dropped; payload pairs high nibble first
    if (!bus.rx_overhead_flag) begin
      if (!c_q.half) begin
        next_c.hi = bus.rx_nibble_bus;
        next_c.half = 1'b1;
      end else begin
        next_c.byte_hold = {c_q.hi, bus.rx_nibble_bus};
        next_c.byte_tog = ~c_q.byte_tog;
        next_c.half = 1'b0;
      end
    end
  end

  always_ff @(posedge bus.rx_nibble_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      c_q <= '0;
    end else begin
      c_q <= next_c;
    end
  end

  // ==========================================================
  // toggle handshake into the system clock; byte_hold stays two nibbles
  always_comb begin
    next_s = s_q;
    next_s.btog = {s_q.btog[1:0], c_q.byte_tog};
    next_s.ftog = {s_q.ftog[1:0], c_q.frame_tog};
    next_s.ok = {s_q.ok[0], c_q.align_ok};
    next_s.valid = s_q.btog[2] ^ s_q.btog[1];
    next_s.frame = s_q.ftog[2] ^ s_q.ftog[1];
    if (s_q.btog[2] ^ s_q.btog[1]) begin
      next_s.data = c_q.byte_hold;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= next_s;
    end
  end

  assign o_byte = s_q.data;
  assign o_byte_valid = s_q.valid;
  assign o_frame_start = s_q.frame;
  assign o_align_ok = s_q.ok[1];

endmodule
`default_nettype wire

//--- include/e3n_if.sv
// system-side nibble link between device and terminal equipment
`default_nettype none
interface e3n_if;
  logic rx_nibble_clock;
  logic [3:0] rx_nibble_bus;
  logic rx_frame_marker;
  logic rx_overhead_flag;

  modport dev (
    output rx_nibble_clock,
    output rx_nibble_bus,
    output rx_frame_marker,
    output rx_overhead_flag
  );

  modport sys (
    input rx_nibble_clock,
    input rx_nibble_bus,
    input rx_frame_marker,
    input rx_overhead_flag
  );
endinterface
`default_nettype wire

//--- include/e3n_params.svh
// constants for the e3 g.832 receive nibble output path
`ifndef E3N_PARAMS_SVH
`define E3N_PARAMS_SVH

// ============================================================
// register offsets
`define E3N_OFS_GLOBAL_OP_SEL 16'h0100
`define E3N_OFS_FRAMING_MODE 16'h1100
`define E3N_OFS_PAYLOAD_PKT 16'h1182

// ============================================================
// field positions
`define E3N_BIT_CFG_CONTROL 0
`define E3N_BIT_FORMAT 2
`define E3N_BIT_DS3_SELECT 6
`define E3N_BIT_PKT_ENABLE 6

// ============================================================
// reset values and writable masks
`define E3N_RST_GLOBAL_OP_SEL 8'h01
`define E3N_RST_FRAMING_MODE 8'h2B
`define E3N_RST_PAYLOAD_PKT 8'h00
`define E3N_MSK_GLOBAL_OP_SEL 8'h01
`define E3N_MSK_FRAMING_MODE 8'hFF
`define E3N_MSK_PAYLOAD_PKT 8'hE8

// ============================================================
// frame geometry and alignment values
`define E3N_FRAME_BYTES 537
`define E3N_OH_BYTES 7
`define E3N_PAYLOAD_BYTES 530
`define E3N_ROWS 9
`define E3N_WIDE_COLS 60
`define E3N_NARROW_COLS 59
`define E3N_FRAME_BITS 13'h10C8
`define E3N_ALIGN_ONE 8'hF6
`define E3N_ALIGN_TWO 8'h28
`define E3N_FA_END_BIT 13'h000F
`define E3N_LOCK_NEXT_BIT 13'h0010
`define E3N_OUT_DELAY 13'h0013

// ============================================================
// rates
`define E3N_FRAMES_PER_SEC 8000
`define E3N_LINE_RATE_HZ 34368000
`define E3N_NIBBLE_DIV 4

`endif

//--- include/e3n_pkg.sv
// types shared by both ends of the receive nibble path
`default_nettype none
package e3n_pkg;

  // ==========================================================
  // framing format, coded as {ds3_select, format}
  typedef enum logic [1:0] {
    E3N_FMT_G751 = 2'b00,
    E3N_FMT_G832 = 2'b01,
    E3N_FMT_DS3_CBIT = 2'b10,
    E3N_FMT_DS3_M13 = 2'b11
  } e3n_format_t;

  // ==========================================================
  // receive alignment state
  typedef enum logic {
    E3N_HUNT = 1'b0,
    E3N_LOCKED = 1'b1
  } e3n_sync_t;

endpackage
`default_nettype wire

//--- verification/e3n_link_assertions.sv
// concurrent checks on the receive nibble link
`include "e3n_params.svh"
`default_nettype none
module e3n_link_chk (
  input wire logic i_line_clk,
  input wire logic i_rst_n,
  input wire logic rx_nibble_clock,
  input wire logic [3:0] rx_nibble_bus,
  input wire logic rx_frame_marker,
  input wire logic rx_overhead_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  import e3n_pkg::*;
  default clocking @(posedge i_line_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========
  // frame trackers; run waits for a first marker so the realign at lock is skipped
  logic run, mk_q;
  logic [12:0] pos, ohc;
  wire rise = rx_frame_marker && !mk_q;
  function automatic logic is_oh(input logic [12:0] j);
    return j < 13'h0010 || (j[12:3] % 60 == 0 && j < 13'h0968);
  endfunction
  always_ff @(posedge i_line_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      run <= 1'b0;
      mk_q <= 1'b0;
      pos <= 13'h0000;
      ohc <= 13'h0000;
    end else begin
      mk_q <= rx_frame_marker;
      run <= run | rise;
      pos <= rise ? 13'h0001 : pos + 13'h0001;
      ohc <= rise ? 13'h0001 : ohc + {12'h000, rx_overhead_flag};
    end
  end
  // ==========
  // assertions
  sequence s_fa;
    rx_nibble_bus == 4'hF && rx_overhead_flag ##4 rx_nibble_bus == 4'h6
      ##4 rx_nibble_bus == 4'h2 ##4 rx_nibble_bus == 4'h8 && rx_overhead_flag;
  endsequence
  sequence s_period;
    rx_nibble_clock ##1 !rx_nibble_clock [*2] ##1 rx_nibble_clock;
  endsequence
  chk_nib_period: assert property (run && $rose(rx_nibble_clock) |=> s_period)
    else $error("nibble clock period is not four line clocks");
  chk_bus_on_fall: assert property (run && $changed({rx_nibble_bus, rx_frame_marker, rx_overhead_flag})
    |-> $fell(rx_nibble_clock)) else $error("link outputs changed off the clock fall");
  chk_marker_fa: assert property (rise |-> $fell(rx_nibble_clock) ##0 s_fa)
    else $error("marker not on alignment nibbles");
  chk_marker_width: assert property (rise |-> rx_frame_marker [*4] ##1 !rx_frame_marker)
    else $error("marker not one nibble wide");
  chk_frame_len: assert property (run && rise |-> pos == `E3N_FRAME_BITS)
    else $error("frame length wrong");
  chk_oh_count: assert property (run && rise |-> ohc == 13'h0038)
    else $error("overhead nibble count wrong");
  chk_oh_place: assert property (run && !rise |-> rx_overhead_flag == is_oh(pos))
    else $error("overhead flag at wrong place");
  chk_flag_byte: assert property (run && $rose(rx_overhead_flag) && !rise
    |-> rx_overhead_flag [*8] ##1 !rx_overhead_flag) else $error("overhead flag not one byte");
endmodule
`default_nettype wire

//--- verification/test_e3_g832_rx_nibble_output.sv
// self-checking bench: device and terminal joined over the nibble link
`include "e3n_params.svh"
`default_nettype none
module test_e3_g832_rx_nibble_output;
  timeunit 1ns;
  timeprecision 1ps;
  import e3n_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_line_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic line_data = 1'b0;
  logic sel = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata, o_byte, cur;
  logic [1:0] fmt;
  logic locked, bvalid, fstart, align_ok;
  logic [31:0] lf = 32'hAE04;
  logic [7:0] tbl [530];
  int err_total = 0;
  int tests_run = 0;
  int nfs = 0;
  int nclk = 0;
  int idx = 0;
  e3n_format_t fl [4] = '{E3N_FMT_G751, E3N_FMT_DS3_CBIT, E3N_FMT_DS3_M13, E3N_FMT_G832};
  e3n_if lnk ();
  e3n_rx_device e3n_rx_device_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_line_clk(i_line_clk),
    .i_line_data(line_data), .i_nibble_mode_select(sel), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_frame_locked(locked), .o_format(fmt), .bus(lnk.dev));
  e3n_sys_sink e3n_sys_sink_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .bus(lnk.sys), .o_byte(o_byte),
    .o_byte_valid(bvalid), .o_frame_start(fstart), .o_align_ok(align_ok));
  e3n_link_chk e3n_link_chk_inst (.i_line_clk(i_line_clk), .i_rst_n(i_rst_n),
    .rx_nibble_clock(lnk.rx_nibble_clock), .rx_nibble_bus(lnk.rx_nibble_bus),
    .rx_frame_marker(lnk.rx_frame_marker), .rx_overhead_flag(lnk.rx_overhead_flag));
  // ==========
  // clocks; the half-ns line half period keeps its rising edges off the reference edges
  always #20 i_ref_clk = ~i_ref_clk;
  always #62.5 i_line_clk = ~i_line_clk;
  // ==========
  // helpers
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic align_in(input logic [23:0] w);
    for (int s = 0; s < 8; s++) begin
      if (w[s +: 16] == {`E3N_ALIGN_ONE, `E3N_ALIGN_TWO}) return 1'b1;
    end
    return 1'b0;
  endfunction
  function automatic logic [7:0] fbyte(input int b);
    if (b == 0) return `E3N_ALIGN_ONE;
    if (b == 1) return `E3N_ALIGN_TWO;
    if (b % 60 == 0 && b <= 300) return 8'hA5;
    return tbl[b - 2 - (b / 60 > 5 ? 5 : b / 60)];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    #1 addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge i_ref_clk);
    #1 wr = 1'b0;
  endtask
  task automatic rreg(input logic [15:0] a, input logic [7:0] e);
    @(posedge i_ref_clk);
    #1 addr = a;
    rd = 1'b1;
    @(posedge i_ref_clk);
    #1 rd = 1'b0;
    @(posedge i_ref_clk);
    #1 chk(16'(rdata), 16'(e));
  endtask
  task automatic summarize();
    if (err_total == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ==========
  // serial frames, msb of each byte first; payload is random but repeats every frame
  // payload never mimics the alignment word, else a single-match hunt locks onto it for good
  initial begin
    for (int i = 0; i < 530; i++) begin
      do begin
        lf = nxt(lf);
      end while (align_in({i > 1 ? tbl[i - 2] : (i > 0 ? `E3N_ALIGN_TWO : `E3N_ALIGN_ONE),
                           i > 0 ? tbl[i - 1] : `E3N_ALIGN_TWO, lf[7:0]}));
      tbl[i] = lf[7:0];
    end
    wait (i_rst_n);
    forever for (int b = 0; b < 537; b++) begin
      cur = fbyte(b);
      for (int k = 7; k >= 0; k--) begin
        @(posedge i_line_clk);
        #1 line_data = cur[k];
      end
    end
  end
  always @(posedge lnk.rx_nibble_clock) nclk++;
  always @(negedge i_ref_clk) begin
    if (fstart === 1'b1) begin
      if (nfs > 0) chk(16'(idx), 16'h0212);
      nfs++;
      idx = 0;
    end
    if (bvalid === 1'b1 && nfs > 0) begin
      chk(16'(o_byte), 16'(tbl[idx]));
      idx++;
    end
  end
  // ==========
  // main sequence
  initial begin
    repeat (16) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    chk(16'(fmt), 16'h0000);
    rreg(`E3N_OFS_GLOBAL_OP_SEL, 8'h01);
    rreg(`E3N_OFS_FRAMING_MODE, 8'h2B);
    rreg(`E3N_OFS_PAYLOAD_PKT, 8'h00);
    wreg(16'h0004, 8'hFF);
    rreg(16'h0004, 8'h00);
    wreg(`E3N_OFS_GLOBAL_OP_SEL, 8'hFE);
    rreg(`E3N_OFS_GLOBAL_OP_SEL, 8'h00);
    wreg(`E3N_OFS_GLOBAL_OP_SEL, 8'h01);
    wreg(`E3N_OFS_PAYLOAD_PKT, 8'hFF);
    rreg(`E3N_OFS_PAYLOAD_PKT, 8'hE8);
    wreg(`E3N_OFS_PAYLOAD_PKT, 8'h00);
    foreach (fl[i]) begin
      wreg(`E3N_OFS_FRAMING_MODE, {1'b0, fl[i][1], 3'b101, fl[i][0], 2'b11});
      repeat (2) @(posedge i_ref_clk);
      #1 chk(16'(fmt), 16'(fl[i]));
    end
    rreg(`E3N_OFS_FRAMING_MODE, 8'h2F);
    // each wait spans more than one frame, so a lock would surely have been found
    wreg(`E3N_OFS_PAYLOAD_PKT, 8'h40);
    repeat (14000) @(posedge i_ref_clk);
    #1 chk(16'(locked), 16'h0000);
    wreg(`E3N_OFS_GLOBAL_OP_SEL, 8'h00);
    wreg(`E3N_OFS_PAYLOAD_PKT, 8'h00);
    repeat (14000) @(posedge i_ref_clk);
    #1 chk(16'(locked), 16'h0000);
    wreg(`E3N_OFS_GLOBAL_OP_SEL, 8'h01);
    repeat (14000) @(posedge i_ref_clk);
    #1 chk(16'(locked), 16'h0001);
    chk(16'(nclk + nfs), 16'h0000);
    sel = 1'b1;
    nclk = 0;
    repeat (45000) @(posedge i_ref_clk);
    #1 chk(16'(nclk >= 3598 && nclk <= 3601), 16'h0001);
    chk(16'(nfs >= 3), 16'h0001);
    chk(16'(locked), 16'h0001);
    chk(16'(align_ok), 16'h0001);
    summarize();
  end
  initial begin
    #4000us;
    err_total++;
    summarize();
  end
endmodule
`default_nettype wire
